/* hw/homing_regs.svh */
/*
 * Named constants for the home switch homing sequencer: method
 * selector codes, step indices and input synchroniser depth.
 * Assumes it is included by the design file only.
 */
`ifndef HOMING_REGS_SVH
`define HOMING_REGS_SVH

`define HOM_M19        8'h13
`define HOM_M20        8'h14
`define HOM_M21        8'h15
`define HOM_M22        8'h16
`define HOM_M23        8'h17
`define HOM_M24        8'h18
`define HOM_M25        8'h19
`define HOM_M26        8'h1a
`define HOM_IDX_FIRST  2'h0
`define HOM_IDX_LAST   2'h2
`define HOM_SYNC_DEPTH 3

`endif

/* hw/homing_pkg.sv */
/*
 * Types shared by the homing sequencer and its bench.
 * Assumes homing_regs.svh is on the include path.
 */
package homing_pkg;

	// One search step of a homing method
	typedef struct packed {
		logic valid;
		logic high;    // 1: high speed, 0: low speed
		logic rev;     // 1: reverse, 0: forward
		logic rise;    // 1: stop on rising edge, 0: on falling edge
	} step_t;

	typedef step_t [2:0] prog_t;

	// Command to the position loop
	typedef struct packed {
		logic run;
		logic high;
		logic rev;
	} motion_cmd_t;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_RUN,
		ST_DECEL
	} hom_state_t;

endpackage

/* hw/home_switch_homing.sv */
/*
 * Homing sequencer for methods 19 to 26: searches home switch edges at
 * high then low speed, or at low speed only when 19 to 24 start on the
 * switch, handles the forward limit for methods 23 to 26.
 * Assumes the position loop follows motion_cmd and reports standstill
 * on motor_stopped; switch and limit pins are asynchronous.
 */
// What this block does
// - Method 19: fast forward to rise, stop, slow reverse to fall.
// - Method 20: fast forward rise, slow reverse fall, slow forward rise.
// - Method 21: fast reverse to rise, stop, slow forward to fall.
// - Method 22: fast reverse rise, slow forward fall, slow reverse rise.
// - Method 23 without limit behaves exactly like method 19.
// - Method 23 at limit: fast reverse fall, slow fwd rise, reverse fall.
// - Method 24 without limit behaves exactly like method 20.
// - Method 24 at limit: fast reverse to fall, slow forward to rise.
// - Method 25: fast forward to fall, stop, slow reverse to rise.
// - Method 25 at limit: fast reverse rise, slow fwd fall, reverse rise.
// - Method 26: fast forward fall, slow reverse rise, slow forward fall.
// - Method 26 at limit: fast reverse to rise, slow forward to fall.
// - Homing runs only while the drive is in position mode.
`timescale 1ns/1ps
`include "homing_regs.svh"

module home_switch_homing
	import homing_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        reset_n,
	// Request
	input  wire logic        start,
	input  wire logic [7:0]  method,
	input  wire logic        position_mode,
	// Position loop
	input  wire logic        motor_stopped,
	output motion_cmd_t      motion_cmd_ff,
	// Switch pins
	input  wire logic        home_sw,
	input  wire logic        fwd_limit,
	// Status
	output logic             busy_ff,
	output logic             done_ff,
	output logic             fault_ff,
	output logic             reject_ff
);

	logic [`HOM_SYNC_DEPTH-1:0] home_sync_ff;
	logic [`HOM_SYNC_DEPTH-1:0] lim_sync_ff;
	logic                       home_lvl_ff;
	logic                       home_prev_ff;
	logic                       lim_lvl_ff;
	hom_state_t                 state_ff;
	hom_state_t                 nxt_state;
	prog_t                      prog_ff;
	prog_t                      nxt_prog;
	logic [1:0]                 idx_ff;
	logic [1:0]                 nxt_idx;
	logic [7:0]                 method_ff;
	logic [7:0]                 nxt_method;
	logic                       lim_seen_ff;
	logic                       nxt_lim_seen;
	logic                       nxt_done;
	logic                       nxt_fault;
	logic                       nxt_reject;
	step_t                      cur;
	step_t                      nxt_step;
	logic                       home_rise;
	logic                       home_fall;
	logic                       edge_hit;
	logic                       method_ok;
	logic                       limit_method;

	function automatic step_t st(input logic high, input logic rev,
		input logic rise);
		st = '{valid: 1'b1, high: high, rev: rev, rise: rise};
	endfunction

	// Step list for a method; act = switch active at start, lim = limit met.
	// A method is a first search, a slow search back to the other edge and,
	// for some, a slow search onto the first edge again.
	function automatic prog_t program_of(input logic [7:0] m,
		input logic act, input logic lim);
		logic  rev0;
		logic  rise0;
		logic  fast;
		logic  third;
		prog_t p;
		// After the limit every method starts back in reverse
		rev0  = lim || m == `HOM_M21 || m == `HOM_M22;
		// 25 and 26 look for a fall first; the limit path swaps the edge
		rise0 = (m <= `HOM_M24) != lim;
		// Only 19 to 24 skip the fast search when starting on the switch
		fast  = lim || !act || m >= `HOM_M25;
		if (lim)
			third = m == `HOM_M23 || m == `HOM_M25;
		else
			third = m == `HOM_M20 || m == `HOM_M22
				|| m == `HOM_M24 || m == `HOM_M26;
		p = '0;
		if (fast)
		begin
			p[0] = st(1'b1, rev0, rise0);
			p[1] = st(1'b0, !rev0, !rise0);
			if (third)
				p[2] = st(1'b0, rev0, rise0);
		end
		else
		begin
			p[0] = st(1'b0, !rev0, !rise0);
			if (third)
				p[1] = st(1'b0, rev0, rise0);
		end
		program_of = p;
	endfunction

	// Pin synchronisers; a level is accepted once stages 2 and 3 agree
	always_ff @(posedge clk_sys)
	begin
		if (!reset_n)
		begin
			home_sync_ff <= '0;
			lim_sync_ff  <= '0;
			home_lvl_ff  <= 1'b0;
			lim_lvl_ff   <= 1'b0;
			home_prev_ff <= 1'b0;
		end
		else
		begin
			home_sync_ff <= {home_sync_ff[1:0], home_sw};
			lim_sync_ff  <= {lim_sync_ff[1:0], fwd_limit};
			if (home_sync_ff[1] == home_sync_ff[2])
				home_lvl_ff <= home_sync_ff[2];
			if (lim_sync_ff[1] == lim_sync_ff[2])
				lim_lvl_ff <= lim_sync_ff[2];
			home_prev_ff <= home_lvl_ff;
		end
	end

	assign home_rise    = home_lvl_ff & ~home_prev_ff;
	assign home_fall    = ~home_lvl_ff & home_prev_ff;
	assign cur          = prog_ff[idx_ff];
	assign edge_hit     = cur.rise ? home_rise : home_fall;
	assign method_ok    = method >= `HOM_M19 && method <= `HOM_M26;
	assign limit_method = method_ff >= `HOM_M23;

	always_comb
	begin
		nxt_state    = state_ff;
		nxt_prog     = prog_ff;
		nxt_idx      = idx_ff;
		nxt_method   = method_ff;
		nxt_lim_seen = lim_seen_ff;
		nxt_done     = 1'b0;
		nxt_fault    = 1'b0;
		nxt_reject   = 1'b0;
		case (state_ff)
			ST_IDLE:
				if (start && method_ok && position_mode)
				begin
					nxt_state    = ST_RUN;
					nxt_method   = method;
					nxt_prog     = program_of(method, home_lvl_ff, 1'b0);
					nxt_idx      = `HOM_IDX_FIRST;
					nxt_lim_seen = 1'b0;
				end
				else if (start)
					nxt_reject = 1'b1;
			ST_RUN:
				if (!position_mode)
				begin
					nxt_state = ST_IDLE;
					nxt_fault = 1'b1;
				end
				else if (idx_ff == `HOM_IDX_FIRST && cur.high && !cur.rev
					&& lim_lvl_ff && !lim_seen_ff)
				begin
					// Only 23..26 may turn back at the limit
					if (limit_method)
					begin
						nxt_prog     = program_of(method_ff, 1'b0, 1'b1);
						nxt_lim_seen = 1'b1;
					end
					else
					begin
						nxt_state = ST_IDLE;
						nxt_fault = 1'b1;
					end
				end
				else if (edge_hit)
				begin
					if (cur.high)
						nxt_state = ST_DECEL;
					else if (idx_ff == `HOM_IDX_LAST
						|| !prog_ff[idx_ff + 2'h1].valid)
					begin
						nxt_state = ST_IDLE;
						nxt_done  = 1'b1;
					end
					else
						nxt_idx = idx_ff + 2'h1;
				end
			ST_DECEL:
				if (!position_mode)
				begin
					nxt_state = ST_IDLE;
					nxt_fault = 1'b1;
				end
				else if (motor_stopped)
				begin
					nxt_state = ST_RUN;
					nxt_idx   = idx_ff + 2'h1;
				end
			default:
				nxt_state = ST_IDLE;
		endcase
	end

	assign nxt_step = nxt_prog[nxt_idx];

	always_ff @(posedge clk_sys)
	begin
		if (!reset_n)
		begin
			state_ff    <= ST_IDLE;
			prog_ff     <= '0;
			idx_ff      <= `HOM_IDX_FIRST;
			method_ff   <= '0;
			lim_seen_ff <= 1'b0;
		end
		else
		begin
			state_ff    <= nxt_state;
			prog_ff     <= nxt_prog;
			idx_ff      <= nxt_idx;
			method_ff   <= nxt_method;
			lim_seen_ff <= nxt_lim_seen;
		end
	end

	// Command is registered from next state so it changes with the state
	always_ff @(posedge clk_sys)
	begin
		if (!reset_n)
			motion_cmd_ff <= '0;
		else if (nxt_state == ST_RUN)
			motion_cmd_ff <= '{run: 1'b1, high: nxt_step.high,
				rev: nxt_step.rev};
		else
			motion_cmd_ff <= '0;
	end

	always_ff @(posedge clk_sys)
	begin
		if (!reset_n)
		begin
			busy_ff   <= 1'b0;
			done_ff   <= 1'b0;
			fault_ff  <= 1'b0;
			reject_ff <= 1'b0;
		end
		else
		begin
			busy_ff   <= nxt_state != ST_IDLE;
			done_ff   <= nxt_done;
			fault_ff  <= nxt_fault;
			reject_ff <= nxt_reject;
		end
	end

endmodule

/* verif/homing_checker.sv */
/* Port checker for the homing sequencer.
   Assumes it is bound onto every home_switch_homing instance. */
`timescale 1ns/1ps
module homing_checker
	import homing_pkg::*;
(
	input wire logic        clk_sys,
	input wire logic        reset_n,
	input wire logic        start,
	input wire logic [7:0]  method,
	input wire logic        position_mode,
	input wire logic        motor_stopped,
	input wire motion_cmd_t motion_cmd_ff,
	input wire logic        busy_ff,
	input wire logic        done_ff,
	input wire logic        fault_ff,
	input wire logic        reject_ff
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	wire logic take = !busy_ff && start && position_mode;
	a_take_runs:
	assert property (take && method >= 8'h13 && method <= 8'h1a
		|=> busy_ff && motion_cmd_ff.run) else $error("start not run");
	a_bad_method:
	assert property (take && (method < 8'h13 || method > 8'h1a)
		|=> reject_ff && !busy_ff) else $error("bad method run");
	a_mode_refuse:
	assert property (!busy_ff && start && !position_mode
		|=> reject_ff && !busy_ff) else $error("mode off run");
	a_mode_abort:
	assert property (busy_ff && !position_mode
		|=> fault_ff && !busy_ff && !motion_cmd_ff.run)
		else $error("no abort");
	a_first_fwd:
	assert property (take && (method == 8'h19 || method == 8'h1a)
		|=> motion_cmd_ff == 3'h6) else $error("first step");
	a_first_rev:
	assert property (take && (method == 8'h15 || method == 8'h16)
		|=> motion_cmd_ff inside {3'h7, 3'h4}) else $error("first step");
	a_decel_wait:
	assert property (busy_ff && !motion_cmd_ff.run && !motor_stopped
		|=> !motion_cmd_ff.run) else $error("moved while coasting");
	a_fast_exit:
	assert property (motion_cmd_ff == 3'h6
		|=> motion_cmd_ff inside {3'h6, 3'h7, 3'h0}) else $error("fast exit");
	a_done_pulse:
	assert property (done_ff |-> !busy_ff && motion_cmd_ff == 3'h0
		##1 !done_ff) else $error("done");
endmodule
bind home_switch_homing homing_checker chk (.clk_sys, .reset_n, .start,
	.method, .position_mode, .motor_stopped, .motion_cmd_ff, .busy_ff,
	.done_ff, .fault_ff, .reject_ff);

/* verif/homing_plant.sv */
/* Motor and switch model: home switch on 100..200, forward limit.
   Assumes the bench loads the position before each run. */
`timescale 1ns/1ps
module homing_plant
	import homing_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire motion_cmd_t cmd,
	input  wire logic        load,
	input  wire logic [11:0] load_pos,
	input  wire logic [11:0] lim_pos,
	input  wire logic [2:0]  coast,
	output logic             home_sw,
	output logic             fwd_limit,
	output logic             motor_stopped
);
	logic [11:0] pos_ff;
	logic [2:0]  left_ff;
	motion_cmd_t was_ff;
	motion_cmd_t mv;
	logic [11:0] stp;
	// Motor coasts after run drops, so every fast edge overshoots
	assign mv = cmd.run ? cmd : was_ff;
	assign stp = mv.high ? 12'h004 : 12'h001;
	always_ff @(posedge clk_sys)
	begin
		if (load)
			left_ff <= 3'h0;
		else if (cmd.run)
			left_ff <= coast;
		else if (left_ff != 3'h0)
			left_ff <= left_ff - 3'h1;
		if (cmd.run)
			was_ff <= cmd;
	end
	always_ff @(posedge clk_sys)
	begin
		if (load)
			pos_ff <= load_pos;
		else if (cmd.run || left_ff != 3'h0)
			pos_ff <= mv.rev ? pos_ff - stp : pos_ff + stp;
	end
	assign home_sw = pos_ff >= 12'h064 && pos_ff <= 12'h0c8;
	assign fwd_limit = pos_ff >= lim_pos;
	assign motor_stopped = !cmd.run && left_ff == 3'h0;
endmodule

/* verif/home_switch_homing_bench.sv */
/* Bench: homing runs on the plant model, refusals and mode loss.
   Assumes the checker is bound by its own file. */
`timescale 1ns/1ps
module home_switch_homing_bench
	import homing_pkg::*;
;
	logic        clk_sys = 1'b0;
	logic        reset_n = 1'b0;
	logic        start = 1'b0;
	logic [7:0]  method = 8'h00;
	logic        position_mode = 1'b1;
	logic        load = 1'b1;
	logic [11:0] load_pos = 12'h000;
	logic [11:0] lim_pos = 12'hfff;
	logic [2:0]  coast = 3'h3;
	motion_cmd_t motion_cmd_ff;
	logic        motor_stopped, home_sw, fwd_limit;
	logic        busy_ff, done_ff, fault_ff, reject_ff;
	int          n_fail = 0;
	int          comparisons = 0;
	initial
		forever #5 clk_sys = ~clk_sys;
	home_switch_homing DUT (.clk_sys, .reset_n, .start, .method,
		.position_mode, .motor_stopped, .motion_cmd_ff, .home_sw,
		.fwd_limit, .busy_ff, .done_ff, .fault_ff, .reject_ff);
	homing_plant plant (.clk_sys, .cmd(motion_cmd_ff), .load, .load_pos,
		.lim_pos, .coast, .home_sw, .fwd_limit, .motor_stopped);
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic tick();
		@(posedge clk_sys);
		#1;
	endtask
	task automatic go(input logic [7:0] m, input logic [11:0] p);
		load = 1'b1;
		load_pos = p;
		repeat (6) tick();
		load = 1'b0;
		method = m;
		start = 1'b1;
		tick();
		start = 1'b0;
	endtask
	// Steps are logged as 3-bit commands each time a running command differs from the last one
	task automatic run_home(input logic [7:0] m, input logic [11:0] p,
		input logic [11:0] l, input logic [15:0] exp);
		motion_cmd_t last;
		logic [15:0] seq;
		int          n;
		last = 3'h0;
		seq = 16'h0000;
		n = 0;
		lim_pos = l;
		go(m, p);
		while (done_ff !== 1'b1 && n < 3000)
		begin
			if (motion_cmd_ff.run && motion_cmd_ff !== last)
				seq = {seq[12:0], motion_cmd_ff};
			last = motion_cmd_ff;
			tick();
			n++;
		end
		if (n == 3000)
		begin
			n_fail++;
			complete_run();
		end
		check(seq, exp);
		check({busy_ff, motion_cmd_ff}, 16'h0000);
	endtask
	task automatic home_19_22();
		run_home(8'h13, 12'h000, 12'hfff, 16'h0035);
		run_home(8'h13, 12'h096, 12'hfff, 16'h0005);
		run_home(8'h14, 12'h000, 12'hfff, 16'h01ac);
		run_home(8'h14, 12'h096, 12'hfff, 16'h002c);
		run_home(8'h15, 12'h12c, 12'hfff, 16'h003c);
		run_home(8'h15, 12'h096, 12'hfff, 16'h0004);
		run_home(8'h16, 12'h12c, 12'hfff, 16'h01e5);
		run_home(8'h16, 12'h096, 12'hfff, 16'h0025);
	endtask
	task automatic home_23_26();
		run_home(8'h17, 12'h000, 12'hfff, 16'h0035);
		run_home(8'h17, 12'h096, 12'hfff, 16'h0005);
		run_home(8'h17, 12'h12c, 12'h190, 16'h0de5);
		run_home(8'h18, 12'h000, 12'hfff, 16'h01ac);
		run_home(8'h18, 12'h096, 12'hfff, 16'h002c);
		run_home(8'h18, 12'h12c, 12'h190, 16'h01bc);
		coast = 3'h6;
		run_home(8'h19, 12'h000, 12'hfff, 16'h0035);
		run_home(8'h19, 12'h096, 12'hfff, 16'h0035);
		run_home(8'h19, 12'h12c, 12'h190, 16'h0de5);
		run_home(8'h1a, 12'h000, 12'hfff, 16'h01ac);
		run_home(8'h1a, 12'h096, 12'hfff, 16'h01ac);
		run_home(8'h1a, 12'h12c, 12'h190, 16'h01bc);
	endtask
	task automatic refuse_and_abort();
		logic [7:0] bad [3] = '{8'h12, 8'h1b, 8'h13};
		int         n;
		lim_pos = 12'hfff;
		foreach (bad[i])
		begin
			position_mode = (i < 2);
			go(bad[i], 12'h000);
			check({reject_ff, busy_ff}, 16'h0002);
		end
		position_mode = 1'b1;
		go(8'h13, 12'h000);
		repeat (5) tick();
		position_mode = 1'b0;
		tick();
		check({fault_ff, busy_ff, motion_cmd_ff}, 16'h0010);
		position_mode = 1'b1;
		// 19 has no limit path: reaching the limit ends the run in a fault
		lim_pos = 12'h190;
		go(8'h13, 12'h12c);
		n = 0;
		while (fault_ff !== 1'b1 && n < 200)
		begin
			tick();
			n++;
		end
		check({fault_ff, busy_ff, motion_cmd_ff}, 16'h0010);
		lim_pos = 12'hfff;
	endtask
	initial
	begin
		repeat (12) @(posedge clk_sys);
		#1 reset_n = 1'b1;
		home_19_22();
		home_23_26();
		refuse_and_abort();
		complete_run();
	end
endmodule
